// ### rtl/pbcs_pkg.sv
// constants, field layouts and carrier types for the basic control/status bank
// assumes one 10 MHz reference clock and a serial management link sampled on it
// Notes on behaviour
// [R1] - writing 1 to control bit 15 resets the device; bit then clears itself
// [R2] - control bit 14 selects loopback; clearing it returns to normal operation
// [R3] - control bit 13 picks 100 or 10 Mbps, resets to 1, ignored under autoneg
// [R4] - control bit 12 enables auto-negotiation; resets to 1
// [R5] - control bit 11 powers down: line and indicator outputs float, MII isolated
// [R6] - control bit 10 isolates MII: transmit inputs ignored, MII outputs floated
// [R7] - isolate bit resets to 0, or to 1 when the address straps are all zero
// [R8] - writing 1 to control bit 9 restarts auto-negotiation; bit then clears itself
// [R9] - control bit 8 picks full or half duplex, resets to 0, ignored under autoneg
// [R10] - collision test asserts COL after TX_EN rises, drops it after TX_EN falls
// [R11] - management writes to the status register are ignored
// [R12] - status bit 15 reads 0; status bits 14 to 11 read 1
// [R13] - status bit 6 mirrors mode control bit 1, which defaults to 1
// [R14] - frames without preamble are rejected unless suppression is indicated
// [R15] - controller sends at least 32 preamble bits before the first frame
// [R16] - controller leaves at least one idle bit between transactions
// [R17] - reset loads control defaults: speed and autoneg 1, all other bits 0; the code also sets isolate when the straps are all zero, as in [R7]
// [R18] - registers are 16 bits; control at address 0, status at address 1
// [R19] - straps give initial values at reset; management takes over afterwards
// [R20] - accesses use the clause 22 frame with 5-bit PHY and register addresses
package pbcs_pkg;

	localparam int REG_W = 16;
	localparam int ADDR_W = 5;
	localparam logic [4:0] CONTROL_REG_INDEX = 5'h00;
	localparam logic [4:0] STATUS_REG_INDEX = 5'h01;
	localparam logic [4:0] MODE_CONTROL_REG = 5'h14;

	typedef struct packed {
		logic soft_reset;
		logic loopback_enable;
		logic speed_select;
		logic autoneg_enable;
		logic power_down;
		logic mii_isolate;
		logic autoneg_restart;
		logic duplex_select;
		logic collision_test;
		logic [6:0] reserved;
	} pbcs_ctrl_s;

	localparam logic [15:0] CTRL_RESET = 16'h3000;
	localparam logic [4:0] STAT_ABILITY = 5'h0F;
	localparam logic [3:0] STAT_RSVD_HI = 4'h0;
	localparam logic [5:0] STAT_LOW_BITS = 6'h00;
	localparam int MODE_PSUP_BIT = 1;
	localparam logic MODE_PSUP_RESET = 1'b1;

	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [5:0] PREAMBLE_MIN = 6'h20;
	localparam logic [4:0] HDR_LAST = 5'h0C;
	localparam logic [4:0] DATA_BITS = 5'h10;
	localparam logic [4:0] WDATA_LAST = 5'h0F;
	localparam logic [4:0] SKIP_LAST = 5'h11;

	localparam int CLK_NS = 100;
	localparam int SOFT_RST_NS = 1000;
	localparam int SOFT_RST_CYCLES = (SOFT_RST_NS + CLK_NS - 1) / CLK_NS;

	typedef struct packed {
		logic tx_en;
		logic tx_er;
		logic [3:0] txd;
	} pbcs_mii_tx_s;

	typedef struct packed {
		logic rx_dv;
		logic rx_er;
		logic [3:0] rxd;
		logic crs;
		logic col;
	} pbcs_mii_rx_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_HDR,
		ST_TA,
		ST_RDATA,
		ST_WDATA,
		ST_SKIP
	} pbcs_mdio_state_e;

endpackage : pbcs_pkg

// ### rtl/pbcs_top.sv
// basic control and status registers behind the serial management port
// assumes mdc and mdio are already synchronous to i_ref_clk (mdc well below 5 MHz)
module pbcs_top (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic [4:0] i_phy_addr,
	input wire logic i_mdc,
	input wire logic i_mdio,
	output logic o_mdio,
	output logic o_mdio_oe,
	input wire pbcs_pkg::pbcs_mii_tx_s i_mii_tx,
	output pbcs_pkg::pbcs_mii_tx_s o_core_tx,
	input wire pbcs_pkg::pbcs_mii_rx_s i_core_rx,
	output pbcs_pkg::pbcs_mii_rx_s o_mii_rx,
	output logic o_mii_oe,
	input wire logic i_an_speed_100,
	input wire logic i_an_full_duplex,
	output logic o_speed_100,
	output logic o_full_duplex,
	output logic o_loopback,
	output logic o_power_down,
	output logic o_autoneg_enable,
	output logic o_autoneg_restart,
	output logic o_soft_reset,
	output logic o_line_tx_oe,
	output logic o_led_oe
);

	pbcs_pkg::pbcs_mdio_state_e state_reg, state_next;
	logic mdc_prev_reg;
	logic [4:0] cnt_reg, cnt_next;
	logic [5:0] pre_cnt_reg, pre_cnt_next;
	logic [15:0] sh_reg, sh_next;
	logic [4:0] reg_addr_reg, reg_addr_next;
	logic is_read_reg, is_read_next;
	logic seen_frame_reg, seen_frame_next;
	logic mdio_out_reg, mdio_out_next;
	logic mdio_oe_reg, mdio_oe_next;
	logic wr_stb;
	logic [15:0] wr_data;
	pbcs_pkg::pbcs_ctrl_s wr_ctrl;
	logic mdc_rise;
	logic [12:0] hdr;

	pbcs_pkg::pbcs_ctrl_s ctrl_reg, ctrl_next, ctrl_dflt;
	logic mode_psup_reg, mode_psup_next;
	logic [4:0] phy_addr_reg;
	logic [7:0] srst_cnt_reg, srst_cnt_next;
	logic [15:0] status_word;

	pbcs_pkg::pbcs_mii_tx_s core_tx_reg, core_tx_next;
	pbcs_pkg::pbcs_mii_rx_s rx_reg, rx_next;
	logic iso_eff;

	function automatic logic [15:0] read_word(input logic [4:0] addr,
			input logic [15:0] ctrl, input logic [15:0] stat, input logic psup);
		logic [15:0] w;
		w = 16'h0000;
		case (addr)
			pbcs_pkg::CONTROL_REG_INDEX: w = ctrl;
			pbcs_pkg::STATUS_REG_INDEX: w = stat;
			pbcs_pkg::MODE_CONTROL_REG: w[pbcs_pkg::MODE_PSUP_BIT] = psup;
			default: w = 16'h0000;
		endcase
		return w;
	endfunction : read_word

	// status is built from constants and the mode bit, so writes have nothing to hit
	assign status_word = {pbcs_pkg::STAT_ABILITY, pbcs_pkg::STAT_RSVD_HI,
		mode_psup_reg, pbcs_pkg::STAT_LOW_BITS}; // [R12] [R13] [R11]

	assign mdc_rise = i_mdc & ~mdc_prev_reg;
	assign hdr = {sh_reg[11:0], i_mdio};
	assign wr_ctrl = wr_data;

	// management frame engine, one step per mdc rising edge
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		pre_cnt_next = pre_cnt_reg;
		sh_next = sh_reg;
		reg_addr_next = reg_addr_reg;
		is_read_next = is_read_reg;
		seen_frame_next = seen_frame_reg;
		mdio_out_next = mdio_out_reg;
		mdio_oe_next = mdio_oe_reg;
		wr_stb = 1'b0;
		wr_data = {sh_reg[14:0], i_mdio};
		if (mdc_rise) begin
			unique case (state_reg)
				pbcs_pkg::ST_IDLE: begin
					if (i_mdio) begin
						if (pre_cnt_reg != pbcs_pkg::PREAMBLE_MIN) begin
							pre_cnt_next = pre_cnt_reg + 6'h01;
						end
					end else begin
						// short preamble only after one good frame [R14] [R15]
						if (pre_cnt_reg == pbcs_pkg::PREAMBLE_MIN
								|| (mode_psup_reg && seen_frame_reg)) begin
							state_next = pbcs_pkg::ST_HDR;
							cnt_next = 5'h00;
						end
						pre_cnt_next = 6'h00;
					end
				end
				pbcs_pkg::ST_HDR: begin
					sh_next = {sh_reg[14:0], i_mdio};
					cnt_next = cnt_reg + 5'h01;
					if (cnt_reg == pbcs_pkg::HDR_LAST) begin
						cnt_next = 5'h00;
						if (hdr[12] && hdr[9:5] == phy_addr_reg
								&& (hdr[11:10] == pbcs_pkg::OP_READ
								|| hdr[11:10] == pbcs_pkg::OP_WRITE)) begin // [R20]
							reg_addr_next = hdr[4:0];
							is_read_next = (hdr[11:10] == pbcs_pkg::OP_READ);
							seen_frame_next = 1'b1;
							state_next = pbcs_pkg::ST_TA;
						end else begin
							state_next = pbcs_pkg::ST_SKIP;
						end
					end
				end
				pbcs_pkg::ST_TA: begin
					if (is_read_reg) begin
						// first turnaround bit left floating, drive 0 in the second
						mdio_oe_next = 1'b1;
						mdio_out_next = 1'b0;
						sh_next = read_word(reg_addr_reg, ctrl_reg, status_word, mode_psup_reg);
						state_next = pbcs_pkg::ST_RDATA;
					end else if (cnt_reg == 5'h01) begin
						state_next = pbcs_pkg::ST_WDATA;
						cnt_next = 5'h00;
					end else begin
						cnt_next = 5'h01;
					end
				end
				pbcs_pkg::ST_RDATA: begin
					if (cnt_reg == pbcs_pkg::DATA_BITS) begin
						mdio_oe_next = 1'b0;
						mdio_out_next = 1'b0;
						state_next = pbcs_pkg::ST_IDLE;
						cnt_next = 5'h00;
					end else begin
						mdio_out_next = sh_reg[15];
						sh_next = {sh_reg[14:0], 1'b0};
						cnt_next = cnt_reg + 5'h01;
					end
				end
				pbcs_pkg::ST_WDATA: begin
					sh_next = {sh_reg[14:0], i_mdio};
					cnt_next = cnt_reg + 5'h01;
					if (cnt_reg == pbcs_pkg::WDATA_LAST) begin
						wr_stb = 1'b1;
						state_next = pbcs_pkg::ST_IDLE;
						cnt_next = 5'h00;
					end
				end
				pbcs_pkg::ST_SKIP: begin
					cnt_next = cnt_reg + 5'h01;
					if (cnt_reg == pbcs_pkg::SKIP_LAST) begin
						state_next = pbcs_pkg::ST_IDLE;
						cnt_next = 5'h00;
					end
				end
				default: state_next = pbcs_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			state_reg <= pbcs_pkg::ST_IDLE;
			// track the idle mdc level so no false rise follows reset
			mdc_prev_reg <= i_mdc;
			cnt_reg <= 5'h00;
			pre_cnt_reg <= 6'h00;
			sh_reg <= 16'h0000;
			reg_addr_reg <= 5'h00;
			is_read_reg <= 1'b0;
			seen_frame_reg <= 1'b0;
			mdio_out_reg <= 1'b0;
			mdio_oe_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			mdc_prev_reg <= i_mdc;
			cnt_reg <= cnt_next;
			pre_cnt_reg <= pre_cnt_next;
			sh_reg <= sh_next;
			reg_addr_reg <= reg_addr_next;
			is_read_reg <= is_read_next;
			seen_frame_reg <= seen_frame_next;
			mdio_out_reg <= mdio_out_next;
			mdio_oe_reg <= mdio_oe_next;
		end
	end

	assign o_mdio = mdio_out_reg;
	assign o_mdio_oe = mdio_oe_reg;

	// register bank
	always_comb begin
		ctrl_dflt = pbcs_pkg::CTRL_RESET; // [R17]
		ctrl_dflt.mii_isolate = (phy_addr_reg == 5'h00); // [R7]
		ctrl_next = ctrl_reg;
		mode_psup_next = mode_psup_reg;
		srst_cnt_next = srst_cnt_reg;
		if (ctrl_reg.autoneg_restart) begin
			ctrl_next.autoneg_restart = 1'b0; // [R8]
		end
		if (ctrl_reg.soft_reset) begin
			// writes during the soft reset are dropped so defaults win cleanly
			if (srst_cnt_reg == 8'(pbcs_pkg::SOFT_RST_CYCLES - 1)) begin
				ctrl_next = ctrl_dflt; // [R1] [R19]
				mode_psup_next = pbcs_pkg::MODE_PSUP_RESET;
				srst_cnt_next = 8'h00;
			end else begin
				srst_cnt_next = srst_cnt_reg + 8'h01;
			end
		end else if (wr_stb && reg_addr_reg == pbcs_pkg::CONTROL_REG_INDEX) begin // [R18]
			ctrl_next = wr_data; // [R2] [R3] [R4] [R5] [R6] [R8] [R9] [R10]
			ctrl_next.reserved = 7'h00; // [R17]
		end else if (wr_stb && reg_addr_reg == pbcs_pkg::MODE_CONTROL_REG) begin
			mode_psup_next = wr_data[pbcs_pkg::MODE_PSUP_BIT]; // [R13]
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			// straps are caught here, on the clocked reset, then left to management
			phy_addr_reg <= i_phy_addr; // [R19]
			ctrl_reg <= pbcs_pkg::CTRL_RESET | {5'h00, i_phy_addr == 5'h00, 10'h000}; // [R7]
			mode_psup_reg <= pbcs_pkg::MODE_PSUP_RESET;
			srst_cnt_reg <= 8'h00;
		end else begin
			ctrl_reg <= ctrl_next;
			mode_psup_reg <= mode_psup_next;
			srst_cnt_reg <= srst_cnt_next;
		end
	end

	// media side controls
	assign iso_eff = ctrl_reg.mii_isolate | ctrl_reg.power_down; // [R5] [R6]
	assign o_speed_100 = ctrl_reg.autoneg_enable ? i_an_speed_100 : ctrl_reg.speed_select; // [R3]
	assign o_full_duplex = ctrl_reg.autoneg_enable ? i_an_full_duplex
		: ctrl_reg.duplex_select; // [R9]
	assign o_loopback = ctrl_reg.loopback_enable; // [R2]
	assign o_autoneg_enable = ctrl_reg.autoneg_enable; // [R4]
	assign o_power_down = ctrl_reg.power_down;
	assign o_autoneg_restart = ctrl_reg.autoneg_restart;
	assign o_soft_reset = ctrl_reg.soft_reset;
	assign o_line_tx_oe = ~ctrl_reg.power_down; // [R5]
	assign o_led_oe = ~ctrl_reg.power_down; // [R5]
	assign o_mii_oe = ~iso_eff; // [R6]

	always_comb begin
		core_tx_next = iso_eff ? '0 : i_mii_tx; // [R6]
		rx_next = i_core_rx;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			core_tx_reg <= '0;
			rx_reg <= '0;
		end else begin
			core_tx_reg <= core_tx_next;
			rx_reg <= rx_next;
		end
	end

	assign o_core_tx = core_tx_reg;

	// col test path kept combinational: one clock is longer than 4 bit times at 100 Mbps
	always_comb begin
		o_mii_rx = rx_reg;
		o_mii_rx.col = rx_reg.col | (ctrl_reg.collision_test & i_mii_tx.tx_en); // [R10]
	end

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_reset);

	soft_rst_clear_a: assert property (ctrl_reg.soft_reset |-> ##[1:12] !ctrl_reg.soft_reset) // [R1]
		else $error("soft reset bit did not clear");
	loop_follow_a: assert property (wr_stb && reg_addr_reg == pbcs_pkg::CONTROL_REG_INDEX
		&& !ctrl_reg.soft_reset |=> o_loopback == $past(wr_ctrl.loopback_enable)) // [R2]
		else $error("loopback output wrong");
	speed_mux_a: assert property (!ctrl_reg.autoneg_enable |-> o_speed_100 == ctrl_reg.speed_select
		&& o_full_duplex == ctrl_reg.duplex_select) // [R3] [R9]
		else $error("manual speed or duplex ignored");
	restart_pulse_a: assert property ($rose(o_autoneg_restart) |=> !o_autoneg_restart) // [R8]
		else $error("restart bit did not self clear");
	pd_float_a: assert property (ctrl_reg.power_down |-> !o_line_tx_oe && !o_led_oe
		&& !o_mii_oe) // [R5]
		else $error("power down outputs still driven");
	iso_gate_a: assert property (ctrl_reg.mii_isolate |-> !o_mii_oe ##1 o_core_tx == '0) // [R6]
		else $error("isolated mii still active");
	col_test_a: assert property (ctrl_reg.collision_test && i_mii_tx.tx_en |-> o_mii_rx.col) // [R10]
		else $error("collision test did not raise col");
	status_const_a: assert property (status_word[15:11] == 5'h0F && status_word[10:7] == 4'h0
		&& status_word[6] == mode_psup_reg) // [R12] [R13]
		else $error("status bits wrong");
	reset_dflt_a: assert property ($past(i_reset) |-> ctrl_reg.speed_select
		&& ctrl_reg.autoneg_enable && !ctrl_reg.soft_reset && !ctrl_reg.collision_test
		&& ctrl_reg.mii_isolate == (phy_addr_reg == 5'h00)) // [R7] [R17]
		else $error("control defaults wrong after reset");
	pre_check_a: assert property (state_reg == pbcs_pkg::ST_IDLE
		&& state_next == pbcs_pkg::ST_HDR && !(mode_psup_reg && seen_frame_reg)
		|-> pre_cnt_reg == pbcs_pkg::PREAMBLE_MIN) // [R14]
		else $error("frame accepted without preamble");
	mdio_drive_a: assert property (o_mdio_oe |-> state_reg == pbcs_pkg::ST_RDATA) // [R20]
		else $error("mdio driven outside read data");

endmodule : pbcs_top

// ### tb/pbcs_mdio_master.sv
// management station model: drives mdc and frames on mdio
// assumes the bench resolves mdio with a pull-up when nobody drives
module pbcs_mdio_master (
	input wire logic i_ref_clk,
	input wire logic i_mdio,
	output logic o_mdc,
	output logic o_mdio,
	output logic o_mdio_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_mdc = 1'b0;
		o_mdio = 1'b1;
		o_mdio_oe = 1'b0;
	end
	// two ref cycles low, two high: mdc well below the sampling rate
	task automatic bit_out(input logic oe, input logic b, output logic s);
		o_mdc = 1'b0;
		o_mdio_oe = oe;
		o_mdio = b;
		repeat (2) @(negedge i_ref_clk);
		s = i_mdio;
		o_mdc = 1'b1;
		repeat (2) @(negedge i_ref_clk);
	endtask : bit_out
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
		input logic [15:0] wd, input int pre, output logic [15:0] rd);
		logic [31:0] w;
		logic s;
		w = {2'b01, op, phy, ra, 2'b10, wd};
		@(negedge i_ref_clk);
		for (int i = 0; i < pre; i++) bit_out(1'b1, 1'b1, s);
		for (int i = 31; i >= 0; i--) begin
			// reads release the line from turnaround on
			bit_out(i > 17 || op == pbcs_pkg::OP_WRITE, w[i], s);
			rd = {rd[14:0], s};
		end
		bit_out(1'b0, 1'b1, s);
	endtask : frame
endmodule : pbcs_mdio_master

// ### tb/test_phy_basic_control_status_regs.sv
// self-checking bench for the basic control and status bank
// assumes the station model file and the design package are compiled first
module test_phy_basic_control_status_regs;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [4:0] RA_CTRL = pbcs_pkg::CONTROL_REG_INDEX;
	localparam logic [4:0] RA_STAT = pbcs_pkg::STATUS_REG_INDEX;
	localparam logic [4:0] RA_MODE = pbcs_pkg::MODE_CONTROL_REG;
	logic clk, rst, mdc, m_do, m_oe, d_do, d_oe, mdio;
	logic [4:0] pa;
	logic an_s, an_f, spd, fd, lb, pd, ane, anr, srst, ltx_oe, led_oe, mii_oe;
	pbcs_pkg::pbcs_mii_tx_s tx, core_tx;
	pbcs_pkg::pbcs_mii_rx_s core_rx, rx;
	int n_fail, n_compared;
	// pull-up on the shared management line
	assign mdio = d_oe ? d_do : (m_oe ? m_do : 1'b1);
	pbcs_mdio_master mgmt (.i_ref_clk(clk), .i_mdio(mdio), .o_mdc(mdc), .o_mdio(m_do),
		.o_mdio_oe(m_oe));
	pbcs_top dut (.i_ref_clk(clk), .i_reset(rst), .i_phy_addr(pa), .i_mdc(mdc),
		.i_mdio(mdio), .o_mdio(d_do), .o_mdio_oe(d_oe), .i_mii_tx(tx), .o_core_tx(core_tx),
		.i_core_rx(core_rx), .o_mii_rx(rx), .o_mii_oe(mii_oe), .i_an_speed_100(an_s),
		.i_an_full_duplex(an_f), .o_speed_100(spd), .o_full_duplex(fd), .o_loopback(lb),
		.o_power_down(pd), .o_autoneg_enable(ane), .o_autoneg_restart(anr),
		.o_soft_reset(srst), .o_line_tx_oe(ltx_oe), .o_led_oe(led_oe));
	always #50 clk = ~clk;
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic chk1(input logic g, input logic e);
		chk({15'h0000, g}, {15'h0000, e});
	endtask : chk1
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] r;
		mgmt.frame(pbcs_pkg::OP_WRITE, pa, ra, d, 32, r);
	endtask : wr
	task automatic rchk(input logic [4:0] ra, input logic [15:0] e, input int pre);
		logic [15:0] r;
		mgmt.frame(pbcs_pkg::OP_READ, pa, ra, 16'h0000, pre, r);
		chk(r, e);
	endtask : rchk
	task automatic t_defaults;
		rchk(RA_CTRL, 16'h3000, 32);
		chk1(d_oe, 1'b0);
		chk1(ane, 1'b1);
		chk1(spd, an_s);
		chk1(fd, an_f);
		chk1(mii_oe & led_oe, 1'b1);
		chk1(lb | pd | srst, 1'b0);
	endtask : t_defaults
	task automatic t_status;
		logic [15:0] r;
		rchk(RA_STAT, 16'h7840, 32);
		wr(RA_STAT, 16'h0000);
		rchk(RA_STAT, 16'h7840, 32);
		rchk(5'h02, 16'h0000, 32);
		mgmt.frame(pbcs_pkg::OP_READ, pa ^ 5'h01, RA_STAT, 16'h0000, 32, r);
		chk(r, 16'hFFFF);
		mgmt.frame(2'h3, pa, RA_CTRL, 16'h0000, 32, r);
		chk(r, 16'hFFFF);
	endtask : t_status
	task automatic t_modes;
		an_s = 1'b1;
		an_f = 1'b0;
		wr(RA_CTRL, 16'h41FF);
		rchk(RA_CTRL, 16'h4180, 32);
		chk1(lb, 1'b1);
		chk1(ane, 1'b0);
		chk1(spd, 1'b0);
		chk1(fd, 1'b1);
		tx = 6'h25;
		@(negedge clk);
		chk({10'h000, core_tx}, 16'h0025);
		chk1(rx.col, 1'b1);
		tx = 6'h00;
		@(negedge clk);
		chk1(rx.col, 1'b0);
		wr(RA_CTRL, 16'h3000);
		chk1(lb, 1'b0);
		tx = 6'h20;
		core_rx = 8'hA4;
		@(negedge clk);
		chk1(rx.col, 1'b0);
		chk({8'h00, rx}, 16'h00A4);
		tx = 6'h00;
		core_rx = 8'h00;
	endtask : t_modes
	task automatic t_isolate;
		wr(RA_CTRL, 16'h3400);
		tx = 6'h3F;
		repeat (2) @(negedge clk);
		chk({10'h000, core_tx}, 16'h0000);
		chk1(mii_oe, 1'b0);
		rchk(RA_CTRL, 16'h3400, 32);
		wr(RA_CTRL, 16'h3800);
		chk1(pd, 1'b1);
		chk1(ltx_oe | led_oe | mii_oe, 1'b0);
		chk({10'h000, core_tx}, 16'h0000);
		wr(RA_CTRL, 16'h3000);
		chk1(ltx_oe & led_oe & mii_oe, 1'b1);
		tx = 6'h00;
	endtask : t_isolate
	task automatic t_restart;
		int n;
		n = 0;
		fork
			wr(RA_CTRL, 16'h3200);
			repeat (300) @(negedge clk) n += int'(anr);
		join
		chk(16'(n), 16'h0001);
		rchk(RA_CTRL, 16'h3000, 32);
	endtask : t_restart
	task automatic t_softrst;
		int n;
		n = 0;
		wr(RA_CTRL, 16'h5000);
		fork
			wr(RA_CTRL, 16'h8000);
			repeat (300) @(negedge clk) n += int'(srst);
		join
		chk(16'(n), 16'(pbcs_pkg::SOFT_RST_CYCLES));
		rchk(RA_CTRL, 16'h3000, 32);
		chk1(lb, 1'b0);
	endtask : t_softrst
	task automatic t_psup;
		rchk(RA_STAT, 16'h7840, 0);
		wr(RA_MODE, 16'h0000);
		rchk(RA_MODE, 16'h0000, 32);
		rchk(RA_STAT, 16'h7800, 32);
		rchk(RA_STAT, 16'hFFFF, 0);
		wr(RA_MODE, 16'h0002);
		rchk(RA_MODE, 16'h0002, 32);
		rchk(RA_STAT, 16'h7840, 0);
	endtask : t_psup
	task automatic t_strap;
		@(negedge clk);
		rst = 1'b1;
		pa = 5'h00;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		rchk(RA_CTRL, 16'h3400, 32);
		chk1(mii_oe, 1'b0);
	endtask : t_strap
	task automatic stop_test;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	// about thirty frames of some 260 cycles each fit well inside this
	initial begin
		#2000000;
		n_fail++;
		stop_test;
	end
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		pa = 5'h05;
		tx = 6'h00;
		core_rx = 8'h00;
		an_s = 1'b0;
		an_f = 1'b1;
		n_fail = 0;
		n_compared = 0;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		t_defaults;
		t_status;
		t_modes;
		t_isolate;
		t_restart;
		t_softrst;
		t_psup;
		t_strap;
		stop_test;
	end
endmodule : test_phy_basic_control_status_regs
